// file: hw/osdd_pkg.sv
// Constants, register map and state types for the output sync and digital delay block
package osdd_pkg;
    localparam int NUM_OUT = 6;
    localparam int ADDR_W = 8;
    localparam int COARSE_W = 10;
    localparam int DIV_W = 8;
    localparam int FB_DIV_W = 18;
    localparam int CTL_W = 13;

    // Register word addresses
    localparam logic [ADDR_W-1:0] ADDR_OUT_CFG_LAST = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_CTL = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_DIVIDER_CFG = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

    // Output configuration word fields
    localparam int CFG_COARSE_LSB = 0;
    localparam int CFG_HS_BIT = 10;
    localparam int CFG_EXEMPT_BIT = 11;
    localparam int CFG_SRC_BIT = 12;
    localparam int CFG_DIV_LSB = 16;

    // Sync control word fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_POL_BIT = 1;
    localparam int CTL_TYPE_LSB = 2;
    localparam int CTL_AUTO_BIT = 5;
    localparam int CTL_QUAL_BIT = 6;
    localparam int CTL_FB_LSB = 7;
    localparam int CTL_UNL1_BIT = 10;
    localparam int CTL_UNL2_BIT = 11;
    localparam int CTL_INTOSC_BIT = 12;

    // Status word fields
    localparam int STS_REQ_BIT = 0;
    localparam int STS_HOLD_BIT = 1;
    localparam int STS_REL_BIT = 2;
    localparam int STS_QST_LSB = 4;
    localparam int STS_CLK_LSB = 8;

    // Reset values, coarse limits and source select mask
    localparam logic [COARSE_W-1:0] COARSE_MIN = 10'h005;
    localparam logic [COARSE_W-1:0] COARSE_MAX = 10'h20A;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h01;
    localparam logic [CTL_W-1:0] CTL_RST = 13'h1001;
    localparam logic [NUM_OUT-1:0] SRC_SEL_MASK = 6'h18;

    // Timing in distribution clock cycles and first polarity-only pin type
    localparam int SYNC_LAT_CYC = 6;
    localparam int QUAL_WAIT_CYC = 3;
    localparam int QUAL_SHOT_CYC = 3;
    localparam logic [1:0] WR_SYNC_CYC = 2'h2;
    localparam logic [COARSE_W-1:0] REL_LOAD_OFS = 10'(SYNC_LAT_CYC - 1);
    localparam logic [2:0] SYNC_TYPE_FIRST_OUT = 3'h3;

    typedef enum logic [3:0] {
        Q_IDLE = 4'h1,
        Q_WAIT_EDGE = 4'h2,
        Q_WAIT3 = 4'h4,
        Q_SHOT = 4'h8
    } osdd_qual_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } osdd_bus_req_t;

    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic [1:0] wr_pulse;
        logic raw_prev;
        logic req_q;
        logic req_prev;
        logic [SYNC_LAT_CYC-1:0] hold_pipe;
        osdd_qual_t qstate;
        logic [1:0] qcnt;
        logic fb_prev;
        logic [CTL_W-1:0] ctl;
        logic [FB_DIV_W-1:0] fb_div;
        logic [NUM_OUT-1:0][COARSE_W-1:0] coarse;
        logic [NUM_OUT-1:0] half_step;
        logic [NUM_OUT-1:0] exempt;
        logic [NUM_OUT-1:0] src_sel;
        logic [NUM_OUT-1:0][DIV_W-1:0] div;
        logic [NUM_OUT-1:0][DIV_W-1:0] div_cnt;
        logic [NUM_OUT-1:0][COARSE_W-1:0] rel_cnt;
        logic [NUM_OUT-1:0] clk_out;
        logic [31:0] rdata;
    } osdd_state_t;
endpackage

// file: hw/osdd_core.sv
// Output synchronization and digital delay control with register port
// What this block does
// - coarse delay 5..522, half step subtracts half
// - relative delay is coarse difference minus half-step
// - new coarse count waits for next sync
// - half-step change acts immediately
// - sync only when enabled; exempt outputs keep running
// - affected outputs low during sync, rise together
// - pin type selects pin or polarity hold
// - pin active level or polarity toggle raises sync
// - loop unlock keeps sync asserted when enabled
// - divider register write syncs with internal oscillator
// - auto sync on output config writes
// - all latencies counted in distribution clocks
// - assertion latched, outputs low six cycles later
// - release after six cycles plus programmed delay
// - reference-sourced outputs not aligned by sync
// - outputs three, four exempt bit always works
// - later syncs realign using current delays
// - qualify mode times sync from output edge
// - feedback select picks the qualifying output
// - exempt or reference-sourced qualifier absolute, otherwise relative
// - one-shot three cycles after qualify, three long
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module osdd_core
    import osdd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire osdd_bus_req_t bus_req,
    output logic [31:0] rdata,
    input wire logic sync_pin,
    input wire logic loop_one_lock_detect_flag,
    input wire logic loop_two_lock_detect_flag,
    output logic [NUM_OUT-1:0] out_clk,
    output logic [NUM_OUT-1:0] half_step_advance,
    output logic sync_hold
);
    osdd_state_t st;
    osdd_state_t nx;
    logic [NUM_OUT-1:0] ref_src;
    logic [NUM_OUT-1:0] aff;
    logic en;
    logic qual;
    logic pin_req;
    logic unl_req;
    logic raw;
    logic req_eff;
    logic fb_clk;
    logic hold;
    logic fell;
    logic [2:0] fb_sel;
    logic [2:0] idx;
    logic [DIV_W-1:0] div_m1;

    function automatic logic [COARSE_W-1:0] clamp_coarse(input logic [COARSE_W-1:0] v);
        if (v < COARSE_MIN)
        begin
            return COARSE_MIN;
        end
        else if (v > COARSE_MAX)
        begin
            return COARSE_MAX;
        end
        return v;
    endfunction

    assign rdata = st.rdata;
    assign out_clk = st.clk_out;
    assign half_step_advance = st.half_step;
    assign sync_hold = st.hold_pipe[SYNC_LAT_CYC-2];

    always_comb
    begin
        nx = st;
        div_m1 = '0;
        idx = bus_req.addr[2:0];
        en = st.ctl[CTL_EN_BIT];
        qual = st.ctl[CTL_QUAL_BIT];
        fb_sel = st.ctl[CTL_FB_LSB +: 3];
        ref_src = st.src_sel & SRC_SEL_MASK;
        aff = ~st.exempt & ~ref_src;
        nx.pin_s1 = sync_pin;
        nx.pin_s2 = st.pin_s1;
        // pin type picks the hold source
        if (st.ctl[CTL_TYPE_LSB +: 3] < SYNC_TYPE_FIRST_OUT)
        begin
            pin_req = st.pin_s2 ^ st.ctl[CTL_POL_BIT];
        end
        else
        begin
            pin_req = st.ctl[CTL_POL_BIT];
        end
        unl_req = (st.ctl[CTL_UNL1_BIT] & ~loop_one_lock_detect_flag)
            | (st.ctl[CTL_UNL2_BIT] & ~loop_two_lock_detect_flag);
        raw = en & (pin_req | unl_req | (st.wr_pulse != 2'h0));
        nx.raw_prev = raw;
        if (st.wr_pulse != 2'h0)
        begin
            nx.wr_pulse = st.wr_pulse - 2'h1;
        end

        nx.rdata = '0;
        if (bus_req.wr)
        begin
            if (bus_req.addr <= ADDR_OUT_CFG_LAST)
            begin
                nx.coarse[idx] = clamp_coarse(bus_req.wdata[CFG_COARSE_LSB +: COARSE_W]);
                // half step goes straight to the output
                nx.half_step[idx] = bus_req.wdata[CFG_HS_BIT];
                nx.exempt[idx] = bus_req.wdata[CFG_EXEMPT_BIT];
                nx.src_sel[idx] = bus_req.wdata[CFG_SRC_BIT] & SRC_SEL_MASK[idx];
                nx.div[idx] = bus_req.wdata[CFG_DIV_LSB +: DIV_W];
                if (st.ctl[CTL_AUTO_BIT])
                begin
                    nx.wr_pulse = WR_SYNC_CYC;
                end
            end
            else if (bus_req.addr == ADDR_SYNC_CTL)
            begin
                // polarity toggle flips the pin compare
                nx.ctl = bus_req.wdata[CTL_W-1:0];
            end
            else if (bus_req.addr == ADDR_DIVIDER_CFG)
            begin
                nx.fb_div = bus_req.wdata[FB_DIV_W-1:0];
                // divider write syncs on internal oscillator
                if (st.ctl[CTL_INTOSC_BIT])
                begin
                    nx.wr_pulse = WR_SYNC_CYC;
                end
            end
        end
        else if (bus_req.rd)
        begin
            if (bus_req.addr <= ADDR_OUT_CFG_LAST)
            begin
                nx.rdata[CFG_COARSE_LSB +: COARSE_W] = st.coarse[idx];
                nx.rdata[CFG_HS_BIT] = st.half_step[idx];
                nx.rdata[CFG_EXEMPT_BIT] = st.exempt[idx];
                nx.rdata[CFG_SRC_BIT] = st.src_sel[idx];
                nx.rdata[CFG_DIV_LSB +: DIV_W] = st.div[idx];
            end
            else if (bus_req.addr == ADDR_SYNC_CTL)
            begin
                nx.rdata[CTL_W-1:0] = st.ctl;
            end
            else if (bus_req.addr == ADDR_DIVIDER_CFG)
            begin
                nx.rdata[FB_DIV_W-1:0] = st.fb_div;
            end
            else if (bus_req.addr == ADDR_STATUS)
            begin
                nx.rdata[STS_REQ_BIT] = st.req_q;
                nx.rdata[STS_HOLD_BIT] = st.hold_pipe[SYNC_LAT_CYC-2];
                // relative when the qualifier is synced itself
                nx.rdata[STS_REL_BIT] = (fb_sel < 3'(NUM_OUT)) ? aff[fb_sel] : 1'b0;
                nx.rdata[STS_QST_LSB +: 4] = st.qstate;
                nx.rdata[STS_CLK_LSB +: NUM_OUT] = st.clk_out;
            end
        end

        fb_clk = (fb_sel < 3'(NUM_OUT)) ? st.clk_out[fb_sel] : 1'b0;
        nx.fb_prev = fb_clk;
        // qualified sync waits for the output edge
        case (st.qstate)
            Q_IDLE:
            begin
                if (qual && raw && !st.raw_prev)
                begin
                    nx.qstate = Q_WAIT_EDGE;
                end
            end
            Q_WAIT_EDGE:
            begin
                if (!qual)
                begin
                    nx.qstate = Q_IDLE;
                end
                else if (st.fb_prev && !fb_clk)
                begin
                    nx.qstate = Q_WAIT3;
                    nx.qcnt = 2'(QUAL_WAIT_CYC - 1);
                end
            end
            Q_WAIT3:
            begin
                if (st.qcnt == 2'h0)
                begin
                    nx.qstate = Q_SHOT;
                    nx.qcnt = 2'(QUAL_SHOT_CYC - 1);
                end
                else
                begin
                    nx.qcnt = st.qcnt - 2'h1;
                end
            end
            Q_SHOT:
            begin
                if (st.qcnt == 2'h0)
                begin
                    nx.qstate = Q_IDLE;
                end
                else
                begin
                    nx.qcnt = st.qcnt - 2'h1;
                end
            end
            default:
            begin
                nx.qstate = Q_IDLE;
            end
        endcase

        req_eff = qual ? (en && st.qstate == Q_SHOT) : raw;
        // request latched on the clock edge
        nx.req_q = req_eff;
        nx.req_prev = st.req_q;
        nx.hold_pipe = {st.hold_pipe[SYNC_LAT_CYC-2:0], st.req_q};
        hold = st.hold_pipe[SYNC_LAT_CYC-2];
        fell = st.req_prev && !st.req_q;

        for (int i = 0; i < NUM_OUT; i++)
        begin
            div_m1 = (st.div[i] == '0) ? '0 : st.div[i] - 8'h01;
            // coarse count sampled only at release
            // release count is latency minus one plus delay
            if (fell)
            begin
                nx.rel_cnt[i] = aff[i] ? st.coarse[i] + REL_LOAD_OFS : '0;
            end
            else if (st.rel_cnt[i] != '0)
            begin
                nx.rel_cnt[i] = st.rel_cnt[i] - 10'h001;
            end
            // held low, then rise on the count
            if (aff[i] && (hold || st.rel_cnt[i] > 10'h001))
            begin
                nx.clk_out[i] = 1'b0;
                nx.div_cnt[i] = '0;
            end
            // equal counts give equal rise edges
            else if (aff[i] && st.rel_cnt[i] == 10'h001)
            begin
                nx.clk_out[i] = 1'b1;
                nx.div_cnt[i] = '0;
            end
            else if (st.div_cnt[i] >= div_m1)
            begin
                nx.clk_out[i] = ~st.clk_out[i];
                nx.div_cnt[i] = '0;
            end
            else
            begin
                nx.div_cnt[i] = st.div_cnt[i] + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.qstate <= Q_IDLE;
            st.ctl <= CTL_RST;
            st.coarse <= {NUM_OUT{COARSE_MIN}};
            st.div <= {NUM_OUT{DIV_RST}};
        end
        else
        begin
            st <= nx;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Release counts only if no new request lands before the output can rise
    sequence s_release5;
        $fell(st.req_q) && aff[0] && st.coarse[0] == COARSE_MIN ##1 !st.req_q [*6];
    endsequence
    sequence s_cfg_write;
        bus_req.wr && bus_req.addr <= ADDR_OUT_CFG_LAST && st.ctl[CTL_AUTO_BIT] && en && !qual;
    endsequence

    property p_low_after_latch;
        $rose(st.req_q) && aff == $past(aff) |-> ##6 (st.clk_out & aff) == 6'h00;
    endproperty
    a_low_after_latch: assert property (p_low_after_latch) else $error("output not low after sync");

    property p_release_delay;
        s_release5 |-> ##4 !st.clk_out[0] ##1 st.clk_out[0];
    endproperty
    a_release_delay: assert property (p_release_delay) else $error("release timing wrong");

    property p_half_step;
        bus_req.wr && bus_req.addr == 8'h00 |=> half_step_advance[0] == $past(bus_req.wdata[CFG_HS_BIT]);
    endproperty
    a_half_step: assert property (p_half_step) else $error("half step not immediate");

    property p_exempt_runs;
        st.exempt[1] && st.div[1] == 8'h01 |=> st.clk_out[1] != $past(st.clk_out[1]);
    endproperty
    a_exempt_runs: assert property (p_exempt_runs) else $error("exempt output stopped");

    property p_disabled;
        !en |=> !st.req_q;
    endproperty
    a_disabled: assert property (p_disabled) else $error("sync while disabled");

    property p_pin_level;
        en && !qual && st.ctl[CTL_TYPE_LSB +: 3] < 3'h3 && st.pin_s2 != st.ctl[CTL_POL_BIT] |=> st.req_q;
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level not latched");

    property p_unlock;
        en && !qual && st.ctl[CTL_UNL1_BIT] && !loop_one_lock_detect_flag |=> st.req_q;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock did not hold sync");

    property p_auto_sync;
        s_cfg_write |=> ##1 st.req_q [*2];
    endproperty
    a_auto_sync: assert property (p_auto_sync) else $error("auto sync missing");

    property p_qual_shot;
        $rose(st.qstate == Q_WAIT3) |-> ##3 (st.qstate == Q_SHOT) [*3] ##1 st.qstate == Q_IDLE;
    endproperty
    a_qual_shot: assert property (p_qual_shot) else $error("one-shot timing wrong");

    property p_pin_sync;
        1'b1 |-> ##2 st.pin_s2 == $past(sync_pin, 2);
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin synchronizer depth wrong");
endmodule

// file: sim/osdd_host.sv
// Host model: register port master, sync pin and lock flags
`timescale 1ns/1ns
module osdd_host
    import osdd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] rdata,
    output osdd_bus_req_t bus_req,
    output logic sync_pin,
    output logic loop_one_lock_detect_flag,
    output logic loop_two_lock_detect_flag
);
    initial
    begin
        bus_req = '0;
        sync_pin = 1'b0;
        loop_one_lock_detect_flag = 1'b1;
        loop_two_lock_detect_flag = 1'b1;
    end

    // One-cycle write strobe; address and data stay put afterwards
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic pin(input logic v);
        @(posedge clk_sys);
        sync_pin <= v;
    endtask

    task automatic lock(input logic a, input logic b);
        @(posedge clk_sys);
        loop_one_lock_detect_flag <= a;
        loop_two_lock_detect_flag <= b;
    endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the output sync and digital delay block
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import osdd_pkg::*;
    logic clk_sys;
    logic arst_n;
    osdd_bus_req_t bus_req;
    logic [31:0] rdata;
    logic sync_pin;
    logic l1;
    logic l2;
    logic [5:0] out_clk;
    logic [5:0] half_step_advance;
    logic sync_hold;
    logic [6:0] obs;
    logic [31:0] d;
    logic [5:0] prv;
    logic tog;
    logic qb;
    int fh[7];
    int mismatches = 0;
    int tests_run = 0;
    int v;
    int en;
    int cw[4] = '{32'h1021, 32'h0001, 32'h0001, 32'h1001};
    int ca[4] = '{5, 5, 7, 7};
    int ce[4] = '{1, 0, 0, 1};
    int cl[4] = '{0, 5, 522, 1023};
    int cx[4] = '{5, 5, 522, 522};

    assign obs = {sync_hold, out_clk};

    osdd_core dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .sync_pin(sync_pin), .loop_one_lock_detect_flag(l1), .loop_two_lock_detect_flag(l2),
        .out_clk(out_clk), .half_step_advance(half_step_advance), .sync_hold(sync_hold));

    osdd_host host (.clk_sys(clk_sys), .rdata(rdata), .bus_req(bus_req), .sync_pin(sync_pin),
        .loop_one_lock_detect_flag(l1), .loop_two_lock_detect_flag(l2));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic exp_req(int t, int p, int pv, int e);
        return logic'(e != 0 && (t < 3 ? pv != p : p != 0));
    endfunction

    // First edge each observed bit is high; masked outputs must toggle every cycle
    task automatic watch(input int len, input logic [5:0] mask);
        fh = '{default: 0};
        tog = 1'b1;
        #1;
        prv = out_clk;
        for (int i = 1; i <= len; i++)
        begin
            @(posedge clk_sys);
            #1;
            for (int k = 0; k < 7; k++)
                if (obs[k] === 1'b1 && fh[k] == 0) fh[k] = i;
            if (((out_clk ^ prv) & mask) !== mask) tog = 1'b0;
            prv = out_clk;
        end
    endtask

    // Outputs 1 exempt, 3 reference sourced: neither may pause
    task automatic do_sync(input int n2);
        host.pin(1'b1);
        watch(12, 6'h0A);
        // Three edges from pin to latch; hold stage shows one cycle before outputs drop
        `CHK(fh[6], 3 + SYNC_LAT_CYC - 1)
        `CHK(out_clk[0] | out_clk[2] | out_clk[4], 1'b0)
        `CHK(tog, 1'b1)
        host.pin(1'b0);
        watch(40, 6'h0A);
        `CHK(fh[0], 14)
        `CHK(fh[4], fh[0])
        `CHK(fh[2] - fh[0], n2 - 5)
        `CHK(tog, 1'b1)
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d, tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(90422));
        arst_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        host.rd(8'h00, d);
        `CHK(d, 32'h00010005)
        host.rd(ADDR_SYNC_CTL, d);
        `CHK(d, {19'h0, CTL_RST})
        host.rd(8'h09, d);
        `CHK(d, 32'h0)
        host.wr(8'h00, 32'h00010405);
        `CHK(half_step_advance, 6'h01)
        for (int i = 0; i < 4; i++)
        begin
            host.wr(8'h05, 32'h00010000 | 32'(cl[i]));
            host.rd(8'h05, d);
            `CHK(d[9:0], 10'(cx[i]))
        end
        host.wr(8'h05, 32'h00010005);
        host.wr(8'h01, 32'h00010805);
        host.wr(8'h02, 32'h00010008);
        host.wr(8'h03, 32'h00011005);
        do_sync(8);
        // Running output must not shift before the next sync
        host.wr(8'h02, 32'h00010014);
        watch(8, 6'h3F);
        `CHK(tog, 1'b1)
        do_sync(20);
        // Relative mode only when the qualifying output is itself synced
        host.wr(ADDR_SYNC_CTL, 32'h1041);
        host.rd(ADDR_STATUS, d);
        `CHK(d[2], 1'b1)
        host.wr(ADDR_SYNC_CTL, 32'h10C1);
        host.rd(ADDR_STATUS, d);
        `CHK(d[2], 1'b0)
        // Qualified by exempt output one: its fall comes one or two edges after the request
        host.pin(1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        qb = out_clk[1];
        watch(16, 6'h0A);
        `CHK(fh[6], QUAL_WAIT_CYC + SYNC_LAT_CYC + 1 + int'(qb))
        `CHK(tog, 1'b1)
        host.pin(1'b0);
        repeat (20) @(posedge clk_sys);
        for (int t = 0; t < 7; t++)
            for (int p = 0; p < 2; p++)
            begin
                v = int'($urandom % 2);
                en = int'($urandom % 4 != 0);
                host.wr(ADDR_SYNC_CTL, 32'h1000 | (32'(t) << 2) | (32'(p) << 1) | 32'(en));
                host.pin(1'(v));
                repeat (5) @(posedge clk_sys);
                host.rd(ADDR_STATUS, d);
                `CHK(d[0], exp_req(t, p, v, en))
            end
        host.pin(1'b0);
        for (int u = 0; u < 2; u++)
        begin
            host.wr(ADDR_SYNC_CTL, 32'h1001 | (32'h400 << u));
            host.lock(1'(u == 1), 1'(u == 0));
            repeat (5) @(posedge clk_sys);
            host.rd(ADDR_STATUS, d);
            `CHK(d[0], 1'b1)
            host.lock(1'b1, 1'b1);
            repeat (5) @(posedge clk_sys);
            host.rd(ADDR_STATUS, d);
            `CHK(d[0], 1'b0)
        end
        for (int i = 0; i < 4; i++)
        begin
            host.wr(ADDR_SYNC_CTL, 32'(cw[i]));
            repeat (20) @(posedge clk_sys);
            host.wr(8'(ca[i]), ca[i] == 7 ? 32'h10 : 32'h00010005);
            watch(14, 6'h00);
            `CHK(logic'(fh[6] != 0), logic'(ce[i]))
        end
        report_and_stop();
    end
endmodule
